// File: rtl/tmr_defs.svh
// Register map, field, reset and count constants of the timer mode control
// What this block does
// - Nonzero output mode routes channel wave to pin, except in reserved mode 13 and for code 01 where the channel cannot toggle; A bits 7:6, B 5:4
// - Output mode meaning depends on non-PWM, fast or dual-slope class
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - Fast: 10 clears on match, sets at ceiling; 11 the reverse
// - Fast code 01: A toggles only in modes 14, 15; B off
// - Fast: match at ceiling ignored when upper bit set; ceiling action stays
// - Dual code 01: A toggles only in modes 8 to 11; B off
// - Dual: 10 clears on up match, sets on down; 11 reverse
// - Control A bits 3:2 read zero and ignore writes
// - Waveform mode joins control A bits 1:0 with control B pair
// - Modes 0, 4, 12: ceiling max, compare A, capture; immediate loads
// - Modes 1-3 dual-slope, fixed ceilings; load at ceiling, flag at floor
// - Fast modes 5-7, 14, 15; load and flag at ceiling
// - Modes 8, 9 dual-slope; load and flag at floor
// - Modes 10, 11 dual-slope; load at ceiling, flag at floor
// - Dual: compare at floor holds low, at ceiling high; inverted opposite
// - Dual: counter turns at ceiling without a hold, ceiling minus one on the next cycle
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_IDX_CTRL_A 8'h80
`define TMR_IDX_CTRL_B 8'h81
`define TMR_ADDR_CTRL_A {2'h0, `TMR_IDX_CTRL_A, 2'h0}
`define TMR_ADDR_CTRL_B {2'h0, `TMR_IDX_CTRL_B, 2'h0}
`define TMR_ADDR_CMP_A 12'h220
`define TMR_ADDR_CMP_B 12'h224
`define TMR_ADDR_CAP 12'h228
`define TMR_ADDR_CNT 12'h22C
`define TMR_ADDR_STAT 12'h230
`define TMR_ADDR_PORT 12'h234
`define TMR_A_OM_HI 7
`define TMR_A_WM 1:0
`define TMR_B_WM 4:3
`define TMR_B_CS 2:0
`define TMR_A_WMASK 8'hF3
`define TMR_B_WMASK 8'hDF
`define TMR_PORT_DIR 1:0
`define TMR_PORT_DATA 5:4
`define TMR_RST8 8'h00
`define TMR_RST16 16'h0000
`define TMR_FLOOR 16'h0000
`define TMR_TOP_MAX 16'hFFFF
`define TMR_TOP8 16'h00FF
`define TMR_TOP9 16'h01FF
`define TMR_TOP10 16'h03FF
`define TMR_WM_PC8 4'h1
`define TMR_WM_PC9 4'h2
`define TMR_WM_PC10 4'h3
`define TMR_WM_COM_A 4'h4
`define TMR_WM_F8 4'h5
`define TMR_WM_F9 4'h6
`define TMR_WM_F10 4'h7
`define TMR_WM_PF_CAP 4'h8
`define TMR_WM_PF_A 4'h9
`define TMR_WM_PC_CAP 4'hA
`define TMR_WM_PC_A 4'hB
`define TMR_WM_COM_CAP 4'hC
`define TMR_WM_RSVD 4'hD
`define TMR_WM_F_CAP 4'hE
`define TMR_WM_F_A 4'hF
`endif

// File: rtl/tmr_pkg.sv
// Types shared by the timer mode control modules
package tmr_pkg;
  typedef enum logic [1:0] {TMR_CLS_NONPWM, TMR_CLS_FAST, TMR_CLS_DUAL}
    tmr_class_type;
  typedef enum logic {TMR_UP, TMR_DOWN} tmr_dir_type;
endpackage : tmr_pkg

// File: rtl/tmr_wave_if.sv
// Per-channel link between counter core and waveform unit
`timescale 1ns/1ps
interface tmr_wave_if;
  import tmr_pkg::*;
  tmr_class_type cls;
  logic [1:0] om;
  logic en;
  logic toggle_ok;
  logic match;
  logic match_up;
  logic at_top;
  logic cmp_floor;
  logic cmp_top;
  logic wave;
  logic drive;
  modport ctl (output cls, om, en, toggle_ok, match, match_up, at_top,
    cmp_floor, cmp_top, input wave, drive);
  modport unit (input cls, om, en, toggle_ok, match, match_up, at_top,
    cmp_floor, cmp_top, output wave, drive);
endinterface : tmr_wave_if

// File: rtl/tmr_wave_unit.sv
// Waveform output unit of one compare channel
`timescale 1ns/1ps
module tmr_wave_unit
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Channel link
  tmr_wave_if.unit wif
);
  import tmr_pkg::*;

  logic wave_q;
  logic wave_d;

  assign wif.wave = wave_q;
  assign wif.drive = wif.en && (wif.om[1] || (wif.om[0] && wif.toggle_ok));

  always_comb
  begin
    wave_d = wave_q;
    case (wif.cls)
      TMR_CLS_NONPWM:
        if (wif.match)
          wave_d = wif.om[1] ? wif.om[0] : (wave_q ^ wif.om[0]);
      TMR_CLS_FAST:
        if (wif.at_top && wif.om[1])
          wave_d = !wif.om[0];
        else if (wif.match && wif.om[1])
          wave_d = wif.om[0];
        else if (wif.match && wif.om[0] && wif.toggle_ok)
          wave_d = !wave_q;
      default:
        if (wif.cmp_floor && wif.om[1])
          wave_d = wif.om[0];
        else if (wif.cmp_top && wif.om[1])
          wave_d = !wif.om[0];
        else if (wif.match && wif.om[1])
          wave_d = wif.match_up ? wif.om[0] : !wif.om[0];
        else if (wif.match && wif.om[0] && wif.toggle_ok)
          wave_d = !wave_q;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wave_q <= 1'b0;
    else
      wave_q <= wave_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  nonpwm_toggle_a: assert property (
    wif.cls == TMR_CLS_NONPWM && wif.match && wif.om == 2'h1
    |=> wave_q != $past(wave_q)) else $error("no toggle on match");
  fast_top_set_a: assert property (
    wif.cls == TMR_CLS_FAST && wif.at_top && wif.om == 2'h2
    |=> wave_q) else $error("fast output not set at ceiling");
  fast_ignore_a: assert property (
    wif.cls == TMR_CLS_FAST && wif.at_top && wif.match && wif.om[1]
    |=> wave_q == !$past(wif.om[0])) else $error("ceiling match not ignored");
  toggle_off_a: assert property (
    wif.om == 2'h1 && !wif.toggle_ok && wif.cls != TMR_CLS_NONPWM
    |=> wave_q == $past(wave_q))
    else $error("disconnected toggle channel changed");
  dual_up_a: assert property (
    wif.cls == TMR_CLS_DUAL && wif.match && wif.match_up && wif.om == 2'h2
    && !wif.cmp_floor && !wif.cmp_top |=> !wave_q)
    else $error("up match did not clear");
  dual_floor_a: assert property (
    wif.cls == TMR_CLS_DUAL && wif.cmp_floor && wif.om == 2'h2
    |=> !wave_q) else $error("floor compare not held low");
endmodule : tmr_wave_unit

// File: rtl/tmr_wave_ctrl.sv
// APB-reached mode and compare-output control of a 16-bit timer
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tmr_wave_ctrl
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Waveform pins
  output logic chan_a_pin_o,
  output logic chan_a_pin_oen_o,
  output logic chan_b_pin_o,
  output logic chan_b_pin_oen_o
);
  import tmr_pkg::*;

  // ********************************
  // State
  // ********************************
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [15:0] cmp_buf_q [2];
  logic [15:0] cmp_q [2];
  logic [15:0] cap_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  tmr_dir_type dir_q;
  tmr_dir_type dir_d;
  logic ovf_q;
  logic [1:0] port_dir_q;
  logic [1:0] port_data_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic pin_q [2];
  logic pin_oen_q [2];

  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ********************************
  // Mode decode
  // ********************************
  wire [3:0] waveform_mode = {ctrl_b_q[`TMR_B_WM], ctrl_a_q[`TMR_A_WM]};

  wire is_fast = waveform_mode inside {`TMR_WM_F8, `TMR_WM_F9,
    `TMR_WM_F10, `TMR_WM_F_CAP, `TMR_WM_F_A};
  wire is_dual = waveform_mode inside {`TMR_WM_PC8, `TMR_WM_PC9,
    `TMR_WM_PC10, `TMR_WM_PF_CAP, `TMR_WM_PF_A, `TMR_WM_PC_CAP,
    `TMR_WM_PC_A};
  wire is_rsvd = waveform_mode == `TMR_WM_RSVD;
  tmr_class_type wave_class;
  assign wave_class = is_fast ? TMR_CLS_FAST :
    is_dual ? TMR_CLS_DUAL : TMR_CLS_NONPWM;

  wire top_from_a = waveform_mode inside {`TMR_WM_COM_A, `TMR_WM_PF_A,
    `TMR_WM_PC_A, `TMR_WM_F_A};
  wire top_from_cap = waveform_mode inside {`TMR_WM_PF_CAP,
    `TMR_WM_PC_CAP, `TMR_WM_COM_CAP, `TMR_WM_F_CAP};
  wire [1:0] res_sel = waveform_mode[1:0];
  wire [15:0] fixed_top = waveform_mode[3] ? `TMR_TOP_MAX :
    res_sel == 2'h1 ? `TMR_TOP8 :
    res_sel == 2'h2 ? `TMR_TOP9 :
    res_sel == 2'h3 ? `TMR_TOP10 : `TMR_TOP_MAX;
  wire [15:0] top_val = top_from_a ? cmp_q[0] :
    top_from_cap ? cap_q : fixed_top;
  wire upd_floor = waveform_mode inside {`TMR_WM_PF_CAP, `TMR_WM_PF_A};
  wire run = |ctrl_b_q[`TMR_B_CS];

  // ********************************
  // APB decode
  // ********************************
  wire setup = psel_i && !penable_i;
  wire hit_ca = paddr_i == `TMR_ADDR_CTRL_A;
  wire hit_cb = paddr_i == `TMR_ADDR_CTRL_B;
  wire hit_cmpa = paddr_i == `TMR_ADDR_CMP_A;
  wire hit_cmpb = paddr_i == `TMR_ADDR_CMP_B;
  wire hit_cap = paddr_i == `TMR_ADDR_CAP;
  wire hit_cnt = paddr_i == `TMR_ADDR_CNT;
  wire hit_st = paddr_i == `TMR_ADDR_STAT;
  wire hit_port = paddr_i == `TMR_ADDR_PORT;
  wire hit = |{hit_ca, hit_cb, hit_cmpa, hit_cmpb, hit_cap, hit_cnt,
    hit_st, hit_port};
  wire [1:0] hit_cmp = {hit_cmpb, hit_cmpa};

  // Writes land at the access edge that carries pready
  wire wr_go = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
  wire wr_ca = wr_go && hit_ca && pstrb_i[0];
  wire wr_cb = wr_go && hit_cb && pstrb_i[0];
  wire wr_cap = wr_go && hit_cap;
  wire cnt_wr = wr_go && hit_cnt;
  wire wr_st = wr_go && hit_st && pstrb_i[0];
  wire wr_port = wr_go && hit_port && pstrb_i[0];

  wire [31:0] rd_w =
    hit_ca ? {24'h000000, ctrl_a_q & `TMR_A_WMASK} :
    hit_cb ? {24'h000000, ctrl_b_q & `TMR_B_WMASK} :
    hit_cmpa ? {16'h0000, cmp_buf_q[0]} :
    hit_cmpb ? {16'h0000, cmp_buf_q[1]} :
    hit_cap ? {16'h0000, cap_q} :
    hit_cnt ? {16'h0000, cnt_q} :
    hit_st ? {31'h00000000, ovf_q} :
    hit_port ? {26'h0000000, port_data_q, 2'h0, port_dir_q} :
    32'h00000000;

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // Zero-wait answer prepared in the setup cycle
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !hit;
      prdata_q <= (setup && hit && !pwrite_i) ? rd_w : 32'h00000000;
    end
  end

  // ********************************
  // Control registers
  // ********************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_a_q <= `TMR_RST8;
      ctrl_b_q <= `TMR_RST8;
    end
    else
    begin
      if (wr_ca)
        ctrl_a_q <= pwdata_i[7:0] & `TMR_A_WMASK;
      if (wr_cb)
        ctrl_b_q <= pwdata_i[7:0] & `TMR_B_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cap_q <= `TMR_RST16;
      port_dir_q <= 2'h0;
      port_data_q <= 2'h0;
    end
    else
    begin
      if (wr_cap)
        cap_q <= merge16(cap_q, pwdata_i, pstrb_i);
      if (wr_port)
      begin
        port_dir_q <= pwdata_i[`TMR_PORT_DIR];
        port_data_q <= pwdata_i[`TMR_PORT_DATA];
      end
    end
  end

  // ********************************
  // Counter
  // ********************************
  wire tick = run && !cnt_wr;
  wire at_top = cnt_q == top_val;
  wire past_top = cnt_q >= top_val;
  wire at_floor = cnt_q == `TMR_FLOOR;
  wire ev_top = tick && at_top;
  wire ev_floor = tick && at_floor && dir_q == TMR_DOWN;
  wire ev_max = tick && cnt_q == `TMR_TOP_MAX;
  wire ovf_set = is_fast ? ev_top :
    is_dual ? ev_floor : ev_max;
  wire cmp_upd = wave_class == TMR_CLS_NONPWM ||
    (upd_floor ? ev_floor : ev_top);

  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (cnt_wr)
      cnt_d = merge16(cnt_q, pwdata_i, pstrb_i);
    else if (run)
    begin
      case (dir_q)
        TMR_UP:
          if (is_dual && past_top)
          begin
            dir_d = TMR_DOWN;
            cnt_d = at_floor ? `TMR_FLOOR : cnt_q - 16'h0001;
          end
          else if (past_top)
            cnt_d = `TMR_FLOOR;
          else
            cnt_d = cnt_q + 16'h0001;
        default:
          if (at_floor)
          begin
            dir_d = TMR_UP;
            cnt_d = cnt_q + 16'h0001;
          end
          else
            cnt_d = cnt_q - 16'h0001;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= `TMR_RST16;
      dir_q <= TMR_UP;
    end
    else
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // Overflow flag: the set beats a clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ovf_q <= 1'b0;
    else
      ovf_q <= ovf_set || (ovf_q && !(wr_st && pwdata_i[0]));
  end

  // ********************************
  // Compare channels
  // ********************************
  tmr_wave_if wif [2] ();
  wire [1:0] toggle_ok;
  assign toggle_ok[0] = wave_class == TMR_CLS_NONPWM ||
    (is_fast && waveform_mode inside {`TMR_WM_F_CAP, `TMR_WM_F_A}) ||
    (is_dual && waveform_mode[3]);
  assign toggle_ok[1] = wave_class == TMR_CLS_NONPWM;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      assign wif[ch].cls = wave_class;
      assign wif[ch].om = ctrl_a_q[`TMR_A_OM_HI - 2 * ch -: 2];
      assign wif[ch].en = !is_rsvd;
      assign wif[ch].toggle_ok = toggle_ok[ch];
      assign wif[ch].match = tick && cnt_q == cmp_q[ch];
      assign wif[ch].match_up = dir_q == TMR_UP;
      assign wif[ch].at_top = ev_top && is_fast;
      assign wif[ch].cmp_floor = cmp_q[ch] == `TMR_FLOOR;
      assign wif[ch].cmp_top = cmp_q[ch] == top_val;

      tmr_wave_unit u_unit (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wif(wif[ch])
      );

      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          cmp_buf_q[ch] <= `TMR_RST16;
          cmp_q[ch] <= `TMR_RST16;
        end
        else
        begin
          if (wr_go && hit_cmp[ch])
            cmp_buf_q[ch] <= merge16(cmp_buf_q[ch], pwdata_i, pstrb_i);
          if (cmp_upd)
            cmp_q[ch] <= cmp_buf_q[ch];
        end
      end

      // Pin: wave when routed, port data otherwise
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          pin_q[ch] <= 1'b0;
          pin_oen_q[ch] <= 1'b1;
        end
        else
        begin
          pin_q[ch] <= wif[ch].drive ? wif[ch].wave : port_data_q[ch];
          pin_oen_q[ch] <= !port_dir_q[ch];
        end
      end
    end
  endgenerate

  assign chan_a_pin_o = pin_q[0];
  assign chan_a_pin_oen_o = pin_oen_q[0];
  assign chan_b_pin_o = pin_q[1];
  assign chan_b_pin_oen_o = pin_oen_q[1];

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  rsv_bits_zero_a: assert property (
    wr_ca |=> ctrl_a_q[3:2] == 2'h0 && prdata_q[3:2] == 2'h0)
    else $error("reserved control bits not zero");
  mode_low_pair_a: assert property (
    wr_ca |=> waveform_mode[1:0] == $past(pwdata_i[1:0]))
    else $error("low mode pair not taken");
  dual_top_hold_a: assert property (
    tick && is_dual && dir_q == TMR_UP && at_top && !at_floor
    |=> dir_q == TMR_DOWN && cnt_q == $past(cnt_q) - 16'h0001)
    else $error("dual-slope ceiling not left after one cycle");
  fast_wrap_a: assert property (
    tick && is_fast && at_top |=> cnt_q == `TMR_FLOOR && ovf_q)
    else $error("fast mode did not wrap with flag");
  dual_floor_ovf_a: assert property (
    tick && is_dual && at_floor && dir_q == TMR_DOWN
    |=> ovf_q && dir_q == TMR_UP)
    else $error("dual-slope floor did not set flag");
  normal_max_a: assert property (
    tick && wave_class == TMR_CLS_NONPWM && cnt_q == `TMR_TOP_MAX
    |=> ovf_q && cnt_q == `TMR_FLOOR)
    else $error("normal overflow missed");
  cmp_now_a: assert property (
    wave_class == TMR_CLS_NONPWM |=> cmp_q[1] == $past(cmp_buf_q[1]))
    else $error("immediate compare load missed");
  cmp_floor_hold_a: assert property (
    upd_floor && is_dual && !ev_floor |=> cmp_q[1] == $past(cmp_q[1]))
    else $error("compare changed away from floor");
  pin_route_a: assert property (
    wif[0].drive |=> pin_q[0] == $past(wif[0].wave))
    else $error("routed wave not on pin");
  chan_b_off_a: assert property (
    wif[1].om == 2'h1 && wave_class != TMR_CLS_NONPWM
    |=> pin_q[1] == $past(port_data_q[1]))
    else $error("channel B routed in PWM toggle code");

  dual_turn_c: cover property (ev_top && is_dual && wif[0].drive);
  fast_pwm_c: cover property (is_fast && wif[1].drive && ev_top);
  ovf_clear_c: cover property (wr_st && ovf_q);
endmodule : tmr_wave_ctrl

// File: testbench/test_tmr_wave_ctrl.sv
// Self-checking bench for the timer mode and compare-output control
`timescale 1ns/1ps
`include "tmr_defs.svh"

module test_tmr_wave_ctrl;
  import tmr_pkg::*;
  // ****************************************
  // Signals and tables
  // ****************************************
  localparam logic [11:0] ADDR_BAD = 12'h3F0;
  // Mode, output code, period, toggle mask
  localparam int TG [11][4] = '{'{4, 1, 17, 3}, '{12, 1, 17, 3},
    '{15, 1, 17, 1}, '{14, 1, 17, 1}, '{9, 1, 32, 1}, '{8, 1, 32, 1},
    '{11, 1, 32, 1}, '{10, 1, 32, 1}, '{5, 1, 256, 0}, '{1, 1, 510, 0},
    '{13, 3, 17, 0}};
  // Mode, output code, compare, period, high cycles per period
  localparam int MS [10][5] = '{'{5, 2, 'h40, 256, 65},
    '{5, 3, 'h40, 256, 191}, '{5, 2, 'hFF, 256, 256},
    '{6, 3, 'h1FF, 512, 0}, '{7, 2, 'h40, 1024, 65},
    '{1, 2, 'h40, 510, 128},
    '{2, 3, 'h40, 1022, 894}, '{3, 2, 'h40, 2046, 128},
    '{1, 2, 'h00, 510, 0}, '{1, 2, 'hFF, 510, 510}};
  logic clk_i;
  logic nrst_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0] pstrb_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic chan_a_pin_o;
  logic chan_a_pin_oen_o;
  logic chan_b_pin_o;
  logic chan_b_pin_oen_o;
  int miscompares;
  int comparisons;
  int hi_a;
  int hi_b;
  logic [31:0] rd;
  logic err_q;
  logic [1:0] p0;

  tmr_wave_ctrl u_dut
  (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .chan_a_pin_o(chan_a_pin_o),
    .chan_a_pin_oen_o(chan_a_pin_oen_o), .chan_b_pin_o(chan_b_pin_o),
    .chan_b_pin_oen_o(chan_b_pin_oen_o)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t pins=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic summarize;
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      summarize();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_val(rd, exp);
  endtask : rdchk

  task automatic set_mode(input int mode, input int om);
    logic [3:0] m;
    logic [1:0] o;
    m = 4'(mode);
    o = 2'(om);
    wr(`TMR_ADDR_CTRL_A, {24'h0, o, o, 2'b00, m[1:0]});
    wr(`TMR_ADDR_CTRL_B, {27'h0, m[3:2], 3'b001});
    wr(`TMR_ADDR_CNT, 32'h0000_0000);
  endtask : set_mode

  // ****************************************
  // Clock and sequence
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial
  begin
    nrst_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'hF;
    miscompares = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdchk(`TMR_ADDR_CTRL_A, 32'h0000_0000);
    rdchk(`TMR_ADDR_CTRL_B, 32'h0000_0000);
    chk_pin({chan_b_pin_oen_o, chan_a_pin_oen_o}, 2'b11);
    wr(`TMR_ADDR_CTRL_A, 32'h0000_00FF);
    rdchk(`TMR_ADDR_CTRL_A, 32'h0000_00F3);
    wr(`TMR_ADDR_CTRL_B, 32'h0000_00FF);
    rdchk(`TMR_ADDR_CTRL_B, 32'h0000_00DF);
    wr(`TMR_ADDR_CTRL_B, 32'h0000_0000);
    apb(1'b0, ADDR_BAD, 32'h0000_0000);
    chk_val({rd[30:0], err_q}, 32'h0000_0001);
    // Routing needs both the mode field and the pin direction
    wr(`TMR_ADDR_CMP_A, 32'h0000_0010);
    wr(`TMR_ADDR_CMP_B, 32'h0000_0010);
    wr(`TMR_ADDR_CAP, 32'h0000_0010);
    wr(`TMR_ADDR_CTRL_A, 32'h0000_00F0);
    wr(`TMR_ADDR_PORT, 32'h0000_0030);
    repeat (3) @(posedge clk_i);
    chk_pin({chan_b_pin_oen_o, chan_a_pin_oen_o}, 2'b11);
    wr(`TMR_ADDR_PORT, 32'h0000_0003);
    repeat (3) @(posedge clk_i);
    chk_pin({chan_b_pin_oen_o, chan_a_pin_oen_o}, 2'b00);
    wr(`TMR_ADDR_CTRL_A, 32'h0000_0000);
    wr(`TMR_ADDR_PORT, 32'h0000_0033);
    repeat (3) @(posedge clk_i);
    chk_pin({chan_b_pin_o, chan_a_pin_o}, 2'b11);
    wr(`TMR_ADDR_PORT, 32'h0000_0003);
    // Non-PWM: set, clear, then toggle on one match each
    wr(`TMR_ADDR_CTRL_B, 32'h0000_0001);
    for (int i = 3; i >= 1; i--)
    begin
      set_mode(0, i);
      repeat (30) @(posedge clk_i);
      chk_pin({chan_b_pin_o, chan_a_pin_o}, {2{i != 2}});
    end
    // Toggle code across mode classes, set code in reserved mode 13
    for (int i = 0; i < 11; i++)
    begin
      set_mode(TG[i][0], TG[i][1]);
      repeat (2 * TG[i][2] + 8) @(posedge clk_i);
      p0 = {chan_b_pin_o, chan_a_pin_o};
      repeat (TG[i][2]) @(posedge clk_i);
      chk_pin({chan_b_pin_o, chan_a_pin_o} ^ p0, 2'(TG[i][3]));
    end
    // Duty cycle in fast and dual-slope modes
    for (int i = 0; i < 10; i++)
    begin
      wr(`TMR_ADDR_CMP_A, 32'(MS[i][2]));
      wr(`TMR_ADDR_CMP_B, 32'(MS[i][2]));
      set_mode(MS[i][0], MS[i][1]);
      repeat (2 * MS[i][3] + 8) @(posedge clk_i);
      hi_a = 0;
      hi_b = 0;
      repeat (MS[i][3])
      begin
        @(posedge clk_i);
        hi_a += int'(chan_a_pin_o === 1'b1);
        hi_b += int'(chan_b_pin_o === 1'b1);
      end
      chk_val(32'(hi_a), 32'(MS[i][4]));
      chk_val(32'(hi_b), 32'(MS[i][4]));
    end
    // Flag stays set once stopped; writing one clears it
    wr(`TMR_ADDR_CTRL_B, 32'h0000_0000);
    rdchk(`TMR_ADDR_STAT, 32'h0000_0001);
    wr(`TMR_ADDR_STAT, 32'h0000_0001);
    rdchk(`TMR_ADDR_STAT, 32'h0000_0000);
    summarize();
  end
endmodule : test_tmr_wave_ctrl
